/* File: verilog/otm_pkg.sv */
package otm_pkg;

    // ------------------------------------------------------------
    // widths and scaling
    // ------------------------------------------------------------
    // quantities are in tenths of a percent of rated value
    localparam int OTM_VAL_W = 16;
    localparam int OTM_CODE_W = 6;
    localparam int OTM_OC_N = 5;

    // ------------------------------------------------------------
    // reset values of the settings
    // ------------------------------------------------------------
    // 100.0 percent
    localparam logic [15:0] OTM_OVL_DEFAULT = 16'h03E8;
    // 3.0 percent
    localparam logic [15:0] OTM_DEV_DEFAULT = 16'h001E;

    // ------------------------------------------------------------
    // output function option codes
    // ------------------------------------------------------------
    localparam logic [5:0] OTM_CODE_OVL_ONE = 6'h03;
    localparam logic [5:0] OTM_CODE_PID_DEV = 6'h04;
    // option code 26 decimal
    localparam logic [5:0] OTM_CODE_OVL_TWO = 6'h1A;

    // terminal level for an inactive function, transistor off
    localparam logic OTM_TERM_IDLE = 1'b1;

    typedef logic [15:0] otm_val_t;

    // one software write to a setting
    typedef struct packed {
        logic wr;
        otm_val_t data;
    } otm_wr_s;

    // the three monitor flags, high while asserted
    typedef struct packed {
        logic overload_warning_one;
        logic overload_warning_two;
        logic pid_deviation_flag;
    } otm_flags_s;

    // current setting values
    typedef struct packed {
        otm_val_t overload_level_one;
        otm_val_t overload_level_two;
        otm_val_t deviation_level;
    } otm_levels_s;

endpackage : otm_pkg

/* File: verilog/otm_cmp.sv */
`timescale 1ns/1ps
module otm_cmp
    import otm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire otm_val_t value,
    input wire otm_val_t level,
    output logic flag
);

    // ------------------------------------------------------------
    // threshold flag
    // ------------------------------------------------------------
    // on equality the flag holds, so a quantity sitting on its
    // threshold cannot make the terminal chatter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (value > level) begin
                flag <= 1'b1;
            end else if (value < level) begin
                flag <= 1'b0;
            end
        end
    end

endmodule : otm_cmp

/* File: verilog/otm_top.sv */
`timescale 1ns/1ps
module otm_top
    import otm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire otm_val_t output_current,
    input wire logic regen_braking,
    input wire otm_val_t pid_setpoint,
    input wire otm_val_t pid_process_var,
    input wire otm_wr_s wr_overload_level_one,
    input wire otm_wr_s wr_overload_level_two,
    input wire otm_wr_s wr_deviation_level,
    input wire logic [OTM_OC_N-1:0][OTM_CODE_W-1:0] oc_code,
    input wire logic [OTM_CODE_W-1:0] relay_code,
    output logic [OTM_OC_N-1:0] oc_term_n,
    output logic relay_contact_terminals_n,
    output otm_flags_s flags,
    output otm_levels_s levels,
    output otm_val_t pid_error
);

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    // overload level reset and write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            levels.overload_level_one <= OTM_OVL_DEFAULT;
        end else if (ce && wr_overload_level_one.wr) begin
            levels.overload_level_one <= wr_overload_level_one.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            levels.overload_level_two <= OTM_OVL_DEFAULT;
        end else if (ce && wr_overload_level_two.wr) begin
            levels.overload_level_two <= wr_overload_level_two.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            levels.deviation_level <= OTM_DEV_DEFAULT;
        end else if (ce && wr_deviation_level.wr) begin
            levels.deviation_level <= wr_deviation_level.data;
        end
    end

    // ------------------------------------------------------------
    // pid error magnitude
    // ------------------------------------------------------------
    otm_val_t next_pid_error;

    always_comb begin
        if (pid_setpoint >= pid_process_var) begin
            next_pid_error = pid_setpoint - pid_process_var;
        end else begin
            next_pid_error = pid_process_var - pid_setpoint;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pid_error <= '0;
        end else if (ce) begin
            pid_error <= next_pid_error;
        end
    end

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    logic flag_ovl_one;
    logic flag_ovl_two;
    logic flag_dev;
    logic regen_seen;

    // braking state registered but read by nothing; it never gates the compare
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regen_seen <= 1'b0;
        end else if (ce) begin
            regen_seen <= regen_braking;
        end
    end

    otm_cmp u_cmp_ovl_one (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .value(output_current),
        .level(levels.overload_level_one),
        .flag(flag_ovl_one)
    );

    otm_cmp u_cmp_ovl_two (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .value(output_current),
        .level(levels.overload_level_two),
        .flag(flag_ovl_two)
    );

    otm_cmp u_cmp_dev (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .value(pid_error),
        .level(levels.deviation_level),
        .flag(flag_dev)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= '0;
        end else if (ce) begin
            flags.overload_warning_one <= flag_ovl_one;
            flags.overload_warning_two <= flag_ovl_two;
            flags.pid_deviation_flag <= flag_dev;
        end
    end

    // ------------------------------------------------------------
    // terminal routing
    // ------------------------------------------------------------
    // codes of other functions are served elsewhere; here they leave
    // the terminal off
    function automatic logic otm_select(input logic [OTM_CODE_W-1:0] code,
                                        input logic f1,
                                        input logic f2,
                                        input logic fd);
        logic sel;
        sel = 1'b0;
        case (code)
            OTM_CODE_OVL_ONE: sel = f1;
            OTM_CODE_OVL_TWO: sel = f2;
            OTM_CODE_PID_DEV: sel = fd;
            default: sel = 1'b0;
        endcase
        return sel;
    endfunction : otm_select

    genvar gi;
    generate
        for (gi = 0; gi < OTM_OC_N; gi++) begin : g_oc
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    oc_term_n[gi] <= OTM_TERM_IDLE;
                end else if (ce) begin
                    oc_term_n[gi] <= ~otm_select(oc_code[gi], flag_ovl_one,
                                                 flag_ovl_two, flag_dev);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            relay_contact_terminals_n <= OTM_TERM_IDLE;
        end else if (ce) begin
            relay_contact_terminals_n <= ~otm_select(relay_code, flag_ovl_one,
                                                     flag_ovl_two, flag_dev);
        end
    end

endmodule : otm_top

/* File: dv/otm_chk.sv */
`timescale 1ns/1ps
module otm_chk
    import otm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire otm_val_t output_current,
    input wire otm_wr_s wr_overload_level_one,
    input wire logic [OTM_OC_N-1:0][OTM_CODE_W-1:0] oc_code,
    input wire logic [OTM_CODE_W-1:0] relay_code,
    input wire logic [OTM_OC_N-1:0] oc_term_n,
    input wire logic relay_contact_terminals_n,
    input wire otm_flags_s flags,
    input wire otm_levels_s levels,
    input wire otm_val_t pid_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // flag lags its compare by two enabled edges, whatever the braking state
    a_ovl_one_set: assert property (
        (ce && output_current > levels.overload_level_one) ##1 ce |=> flags[2])
        else $error("overload one not set");
    a_ovl_one_clr: assert property (
        (ce && output_current < levels.overload_level_one) ##1 ce |=> !flags[2])
        else $error("overload one not cleared");
    a_ovl_two_set: assert property (
        (ce && output_current > levels.overload_level_two) ##1 ce |=> flags[1])
        else $error("overload two not set");
    a_ovl_two_clr: assert property (
        (ce && output_current < levels.overload_level_two) ##1 ce |=> !flags[1])
        else $error("overload two not cleared");
    a_dev_set: assert property (
        (ce && pid_error > levels.deviation_level) ##1 ce |=> flags[0])
        else $error("deviation not set");
    a_dev_clr: assert property (
        (ce && pid_error < levels.deviation_level) ##1 ce |=> !flags[0])
        else $error("deviation not cleared");
    a_eq_hold: assert property (
        (ce && output_current == levels.overload_level_one) ##1 ce |=> $stable(flags[2]))
        else $error("flag moved on equality");
    a_term_map: assert property (
        ce && oc_code[0] == OTM_CODE_OVL_ONE |=> oc_term_n[0] == !flags[2])
        else $error("terminal not active low");
    a_relay_map: assert property (
        ce && relay_code == OTM_CODE_OVL_TWO |=> relay_contact_terminals_n == !flags[1])
        else $error("relay not active low");
    a_level_wr: assert property (
        ce && wr_overload_level_one.wr |=>
        levels.overload_level_one == $past(wr_overload_level_one.data))
        else $error("level write lost");
endmodule : otm_chk
bind otm_top otm_chk i_chk (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .output_current(output_current),
    .wr_overload_level_one(wr_overload_level_one),
    .oc_code(oc_code),
    .relay_code(relay_code),
    .oc_term_n(oc_term_n),
    .relay_contact_terminals_n(relay_contact_terminals_n),
    .flags(flags),
    .levels(levels),
    .pid_error(pid_error)
);

/* File: dv/otm_relay_coil.sv */
`timescale 1ns/1ps
module otm_relay_coil (
    input wire logic drive_n,
    output logic energized
);
    // coil pulls in only while the transistor conducts
    assign energized = (drive_n === 1'b0);
endmodule : otm_relay_coil

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench import otm_pkg::*;;
    logic clk = 0;
    logic nrst = 0;
    logic ce = 1;
    logic regen = 0;
    otm_val_t cur = 0;
    otm_val_t sp = 0;
    otm_val_t pv = 0;
    otm_wr_s w [3];
    logic [OTM_OC_N-1:0][OTM_CODE_W-1:0] codes;
    logic [OTM_CODE_W-1:0] rcode;
    logic [OTM_OC_N-1:0] term_n;
    logic relay_n;
    logic coil;
    otm_flags_s flags;
    otm_levels_s levels;
    otm_val_t err;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    otm_top i_dut (.clk(clk), .nrst(nrst), .ce(ce), .output_current(cur),
        .regen_braking(regen), .pid_setpoint(sp), .pid_process_var(pv),
        .wr_overload_level_one(w[0]), .wr_overload_level_two(w[1]),
        .wr_deviation_level(w[2]), .oc_code(codes), .relay_code(rcode),
        .oc_term_n(term_n), .relay_contact_terminals_n(relay_n), .flags(flags),
        .levels(levels), .pid_error(err));
    otm_relay_coil i_coil (.drive_n(relay_n), .energized(coil));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic wr_lvl(input int k, input otm_val_t d);
        w[k] = '{1'b1, d};
        step(1);
        w[k].wr = 1'b0;
    endtask : wr_lvl
    // ----------------------------------------
    // scenarios after t_reset, each waits out the 3-edge pid path
    // ----------------------------------------
    task automatic t_reset;
        chk(levels.overload_level_one, OTM_OVL_DEFAULT);
        chk(levels.overload_level_two, OTM_OVL_DEFAULT);
        chk(levels.deviation_level, OTM_DEV_DEFAULT);
        chk({term_n, relay_n}, 6'h3F);
    endtask : t_reset
    task automatic t_overload;
        regen = 1'b1;
        cur = OTM_OVL_DEFAULT + 16'h0001;
        step(3);
        chk(term_n, 5'h1C);
        chk(coil, 1'b1);
        cur = OTM_OVL_DEFAULT;
        step(3);
        chk(flags, 3'h6);
        cur = OTM_OVL_DEFAULT - 16'h0001;
        step(3);
        chk(flags, 3'h0);
        regen = 1'b0;
    endtask : t_overload
    task automatic t_write;
        ce = 1'b0;
        wr_lvl(1, 16'h01F4);
        ce = 1'b1;
        chk(levels.overload_level_two, OTM_OVL_DEFAULT);
        // a strobe just lowered is not raised again in the same step
        step(1);
        wr_lvl(1, 16'h01F4);
        wr_lvl(0, 16'h07D0);
        chk(levels.overload_level_one, 16'h07D0);
        chk(levels.overload_level_two, 16'h01F4);
        chk(levels.deviation_level, OTM_DEV_DEFAULT);
        cur = 16'h0258;
        step(3);
        chk(flags, 3'h2);
        chk(relay_n, 1'b0);
        cur = 16'h0000;
    endtask : t_write
    task automatic t_pid;
        rcode = OTM_CODE_PID_DEV;
        sp = 16'h0064;
        pv = 16'h01F4;
        step(3);
        chk(err, 16'h0190);
        chk({term_n[2], coil}, 2'h1);
        sp = 16'h01F4;
        pv = 16'h0064;
        wr_lvl(2, 16'h0190);
        step(3);
        chk(err, 16'h0190);
        chk(flags, 3'h1);
        pv = 16'h01F3;
        step(3);
        chk(flags, 3'h0);
        chk(err, 16'h0001);
    endtask : t_pid
    task automatic end_of_test;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        forever #12.5 clk = ~clk;
    end
    // whole run is well under a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        foreach (w[i]) w[i] = '0;
        codes = {12'h000, OTM_CODE_PID_DEV, OTM_CODE_OVL_TWO, OTM_CODE_OVL_ONE};
        rcode = OTM_CODE_OVL_TWO;
        step(2);
        nrst = 1'b1;
        step(1);
        t_reset();
        t_overload();
        t_write();
        t_pid();
        // reset in mid-run must bring back the defaults over written levels
        nrst = 1'b0;
        step(1);
        t_reset();
        chk(err, 16'h0000);
        end_of_test();
    end
endmodule : testbench
